// *** rtl/clk_rst_pkg.sv ***
package clk_rst_pkg;
  // Register offsets (byte addresses from the system-control base)
  localparam logic [11:0] OFF_SOFT_RESET_0 = 12'h040;
  localparam logic [11:0] OFF_SOFT_RESET_1 = 12'h044;
  localparam logic [11:0] OFF_SOFT_RESET_2 = 12'h048;
  localparam logic [11:0] OFF_RUN_GATE_2 = 12'h108;
  localparam logic [11:0] OFF_SLEEP_GATE_2 = 12'h118;
  localparam logic [11:0] OFF_DEEP_GATE_2 = 12'h128;
  localparam logic [11:0] OFF_RUN_CLOCK_CONFIG = 12'h060;
  localparam logic [11:0] OFF_POWER_STATUS = 12'h180;
  // Implemented bits of the soft-reset and gating registers
  localparam logic [31:0] MASK_SOFT_RESET_0 = 32'h0011_0008;
  localparam logic [31:0] MASK_SOFT_RESET_1 = 32'h010F_5011;
  localparam logic [31:0] MASK_GATE_2 = 32'h0000_201F;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
  // Field positions
  localparam int DMA_UNIT_BIT = 13;
  localparam int PORT_E_BIT = 4;
  localparam int PORT_A_BIT = 0;
  localparam int WATCHDOG_BIT = 3;
  localparam int ADC_BIT = 16;
  localparam int PWM_BIT = 20;
  localparam int AUTO_GATING_SELECT_BIT = 27;
  // Number of gated units in the gating registers
  localparam int GATED_UNITS = 6;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_SLEEP,
    PWR_DEEP_SLEEP
  } power_state_t;

  // Software-reset outputs, one bundle
  typedef struct packed {
    logic [31:0] word0;
    logic [31:0] word1;
    logic [31:0] word2;
  } soft_reset_t;

  // Peripheral access request: valid flag and unit number
  typedef struct packed {
    logic valid;
    logic [2:0] unit;
  } unit_access_t;
endpackage

// *** rtl/clock_gate_soft_reset.sv ***
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - selected deep-sleep gating bits 13 and 4..0 enable their unit clocks.
// - access to a unit whose clock is gated off returns a bus fault.
// - all gating bits reset to zero, units unclocked.
// - separate run, sleep and deep-sleep gating words chosen by power state.
// - sleep words apply only with auto gating set, else run word.
// - writes to soft reset word 0 masked by capability word one.
// - writes to soft reset word 1 masked by capability word two.
// - writes to soft reset word 2 masked by capability word four.
// - word 0 has PWM bit 20, converter bit 16, watchdog bit 3.
// - word 1 has comparator 24, timers 19..16, two-wire 14,12, serial 4,0.
// - word 2 has DMA bit 13 and ports E..A at bits 4..0.
// - all software-reset bits reset to zero.
// - reserved bits read zero and ignore writes.
module clock_gate_soft_reset (
  input wire logic i_ref_clk, // System clock, 125 MHz
  input wire logic i_rst_n, // Async reset, active low
  input wire logic [11:0] i_addr, // Register byte offset
  input wire logic [31:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [31:0] o_rdata, // Read data, one cycle later
  input wire logic [31:0] i_cap_one, // Capability word one
  input wire logic [31:0] i_cap_two, // Capability word two
  input wire logic [31:0] i_cap_four, // Capability word four
  input wire clk_rst_pkg::power_state_t i_power_state, // Power state
  input wire clk_rst_pkg::unit_access_t i_access, // Peripheral access
  output logic o_access_fault, // Bus fault, cycle after access
  output logic [31:0] o_clock_enable, // Unit clock enables in force
  output var clk_rst_pkg::soft_reset_t o_soft_reset // Peripheral resets held
);
  import clk_rst_pkg::*;

  // Every check below runs on the system clock and sleeps in reset
  default clocking cb_sys @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  logic [31:0] run_gate;
  logic [31:0] sleep_gate;
  logic [31:0] deep_gate;
  logic [31:0] run_cfg;
  logic [31:0] srst0;
  logic [31:0] srst1;
  logic [31:0] srst2;
  logic [31:0] gate_now;
  logic [31:0] next_rdata;
  logic [GATED_UNITS-1:0] unit_on;
  logic wr_run;
  logic wr_sleep;
  logic wr_deep;
  logic wr_cfg;
  logic wr_s0;
  logic wr_s1;
  logic wr_s2;
  logic auto_gating;

  // Address decode of write strobes
  assign wr_run = i_wr && (i_addr == OFF_RUN_GATE_2);
  assign wr_sleep = i_wr && (i_addr == OFF_SLEEP_GATE_2);
  assign wr_deep = i_wr && (i_addr == OFF_DEEP_GATE_2);
  assign wr_cfg = i_wr && (i_addr == OFF_RUN_CLOCK_CONFIG);
  assign wr_s0 = i_wr && (i_addr == OFF_SOFT_RESET_0);
  assign wr_s1 = i_wr && (i_addr == OFF_SOFT_RESET_1);
  assign wr_s2 = i_wr && (i_addr == OFF_SOFT_RESET_2);
  assign auto_gating = run_cfg[AUTO_GATING_SELECT_BIT];

  // Three gating words, reset to unclocked
  masked_reg #(.IMPL_MASK(MASK_GATE_2), .RST_VAL(RESET_VALUE)) u_run (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_we(wr_run),
    .i_wdata(i_wdata), .i_cap_mask(32'hFFFF_FFFF), .o_value(run_gate)
  );
  masked_reg #(.IMPL_MASK(MASK_GATE_2), .RST_VAL(RESET_VALUE)) u_sleep (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_we(wr_sleep),
    .i_wdata(i_wdata), .i_cap_mask(32'hFFFF_FFFF), .o_value(sleep_gate)
  );
  masked_reg #(.IMPL_MASK(MASK_GATE_2), .RST_VAL(RESET_VALUE)) u_deep (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_we(wr_deep),
    .i_wdata(i_wdata), .i_cap_mask(32'hFFFF_FFFF), .o_value(deep_gate)
  );
  // Only the auto-gating bit is kept of the run clock config word
  masked_reg #(.IMPL_MASK(32'h0800_0000), .RST_VAL(RESET_VALUE)) u_cfg (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_we(wr_cfg),
    .i_wdata(i_wdata), .i_cap_mask(32'hFFFF_FFFF), .o_value(run_cfg)
  );

  // Software-reset words, writes masked by capabilities
  masked_reg #(.IMPL_MASK(MASK_SOFT_RESET_0), .RST_VAL(RESET_VALUE)) u_s0 (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_we(wr_s0),
    .i_wdata(i_wdata), .i_cap_mask(i_cap_one), .o_value(srst0)
  );
  masked_reg #(.IMPL_MASK(MASK_SOFT_RESET_1), .RST_VAL(RESET_VALUE)) u_s1 (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_we(wr_s1),
    .i_wdata(i_wdata), .i_cap_mask(i_cap_two), .o_value(srst1)
  );
  masked_reg #(.IMPL_MASK(MASK_GATE_2), .RST_VAL(RESET_VALUE)) u_s2 (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_we(wr_s2),
    .i_wdata(i_wdata), .i_cap_mask(i_cap_four), .o_value(srst2)
  );

  // Bits of absent units keep their old value; the previous cycle's
  // capability word is used since the words may change at any time
  a_mask_s0: assert property (
    wr_s0 |=> (srst0 & ~$past(i_cap_one)) ==
              ($past(srst0) & ~$past(i_cap_one)))
    else $error("soft reset 0 write not masked");
  a_mask_s1: assert property (
    wr_s1 |=> (srst1 & ~$past(i_cap_two)) ==
              ($past(srst1) & ~$past(i_cap_two)))
    else $error("soft reset 1 write not masked");
  a_mask_s2: assert property (
    wr_s2 |=> (srst2 & ~$past(i_cap_four)) ==
              ($past(srst2) & ~$past(i_cap_four)))
    else $error("soft reset 2 write not masked");

  // Only the unit positions of each word can ever be set
  a_word0_layout: assert property (
    (srst0 & ~MASK_SOFT_RESET_0) == 32'h0000_0000)
    else $error("soft reset 0 reserved bit set");
  a_word1_layout: assert property (
    (srst1 & ~MASK_SOFT_RESET_1) == 32'h0000_0000)
    else $error("soft reset 1 reserved bit set");
  // Word 2 shares the DMA and port layout of the gating words
  a_word2_layout: assert property (
    (srst2 & ~MASK_GATE_2) == 32'h0000_0000)
    else $error("soft reset 2 reserved bit set");

  // Gating word in force for the power state
  gate_select u_sel (
    .i_state(i_power_state),
    .i_auto_gating(auto_gating),
    .i_run(run_gate),
    .i_sleep(sleep_gate),
    .i_deep(deep_gate),
    .o_gate(gate_now)
  );

  // Clock enables registered so outputs come from flops
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_clock_enable <= RESET_VALUE;
    end else begin
      o_clock_enable <= gate_now;
    end
  end

  // Which power state and auto-gating setting selects each word
  sequence s_sleep_pick;
    i_power_state == PWR_SLEEP && auto_gating;
  endsequence
  sequence s_deep_pick;
    i_power_state == PWR_DEEP_SLEEP && auto_gating;
  endsequence
  sequence s_run_pick;
    i_power_state == PWR_RUN;
  endsequence

  // The enables lag the selected word by one register stage, which
  // keeps glitches of the select path away from the unit clock gates
  a_deep_gate_applies: assert property (
    s_deep_pick |=> o_clock_enable == $past(deep_gate))
    else $error("deep-sleep gating not applied");
  a_sleep_gate: assert property (
    s_sleep_pick |=> o_clock_enable == $past(sleep_gate))
    else $error("sleep gating not applied");
  a_run_state: assert property (
    s_run_pick |=> o_clock_enable == $past(run_gate))
    else $error("run gating not in force in run");
  // Without auto gating a sleeping core keeps its run-time clocks
  a_run_without_auto: assert property (
    !auto_gating |=> o_clock_enable == $past(run_gate))
    else $error("run gating not in force");
  a_gate_reserved: assert property (
    (o_clock_enable & ~MASK_GATE_2) == 32'h0000_0000)
    else $error("clock enable on unimplemented unit");

  // Reset hold outputs follow the reset words
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_soft_reset <= '0;
    end else begin
      o_soft_reset <= {srst0, srst1, srst2};
    end
  end

  // A write reaches the reset outputs two edges after its strobe:
  // one edge into the word, one more into the output flops
  sequence s_wdog_set;
    wr_s0 && i_cap_one[WATCHDOG_BIT] && i_wdata[WATCHDOG_BIT];
  endsequence
  sequence s_wdog_held;
    ##1 o_soft_reset.word0[WATCHDOG_BIT];
  endsequence
  a_reset_follows: assert property (
    1'b1 |=> o_soft_reset == $past({srst0, srst1, srst2}))
    else $error("reset output lags word");
  a_watchdog_bit: assert property (
    s_wdog_set |=> s_wdog_held)
    else $error("watchdog reset bit not held");

  // Per-unit enable for the access check: ports A..E and DMA
  genvar g;
  generate
    for (g = 0; g < GATED_UNITS; g++) begin : g_unit
      if (g < GATED_UNITS - 1) begin : g_port
        assign unit_on[g] = gate_now[PORT_A_BIT + g];
      end else begin : g_dma
        assign unit_on[g] = gate_now[DMA_UNIT_BIT];
      end
    end
  endgenerate

  // Fault on access to an unclocked unit; out-of-range unit also faults
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_access_fault <= 1'b0;
    end else if (i_access.valid) begin
      o_access_fault <= (int'(i_access.unit) >= GATED_UNITS) ||
                        !unit_on[i_access.unit];
    end else begin
      o_access_fault <= 1'b0;
    end
  end

  // Fault answer is a one-cycle pulse after the access only; it uses
  // the word in force at the request, not the registered enables
  sequence s_port_a_gated;
    i_access.valid && i_access.unit == 3'h0 && !gate_now[PORT_A_BIT];
  endsequence
  sequence s_dma_clocked;
    i_access.valid && i_access.unit == 3'h5 && gate_now[DMA_UNIT_BIT];
  endsequence
  a_gated_fault: assert property (
    s_port_a_gated |=> o_access_fault)
    else $error("no fault on gated unit");
  a_dma_no_fault: assert property (
    s_dma_clocked |=> !o_access_fault)
    else $error("fault on clocked unit");
  // Unit numbers past the DMA unit name nothing and must fault
  a_bad_unit: assert property (
    i_access.valid && i_access.unit > 3'h5 |=> o_access_fault)
    else $error("no fault on unknown unit");
  a_fault_pulse: assert property (
    !i_access.valid |=> !o_access_fault)
    else $error("fault without access");

  // Read mux; reserved bits are zero since stores never set them
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (i_addr)
      OFF_RUN_GATE_2: next_rdata = run_gate;
      OFF_SLEEP_GATE_2: next_rdata = sleep_gate;
      OFF_DEEP_GATE_2: next_rdata = deep_gate;
      OFF_RUN_CLOCK_CONFIG: next_rdata = run_cfg;
      OFF_SOFT_RESET_0: next_rdata = srst0;
      OFF_SOFT_RESET_1: next_rdata = srst1;
      OFF_SOFT_RESET_2: next_rdata = srst2;
      OFF_POWER_STATUS: next_rdata = {30'h0000_0000, i_power_state};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data valid the cycle after the strobe only
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // Read data checks; bits 27 and 1:0 are the config and status fields
  a_reserved_zero: assert property (
    i_rd |=> (o_rdata & ~MASK_GATE_2 & ~MASK_SOFT_RESET_0 & ~MASK_SOFT_RESET_1
              & 32'hF7FF_FFFC) == 32'h0000_0000)
    else $error("reserved bits read nonzero");
  // Data must vanish after its one cycle, else a stale word is taken
  a_rdata_idle: assert property (
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data outlived its cycle");
  a_read_deep: assert property (
    i_rd && i_addr == OFF_DEEP_GATE_2 |=> o_rdata == $past(deep_gate))
    else $error("deep-sleep word read back wrong");
  a_read_status: assert property (
    i_rd && i_addr == OFF_POWER_STATUS
      |=> o_rdata[1:0] == $past(i_power_state))
    else $error("power status read back wrong");

  // Read-back of the first reset word; the config word holds only its kept bit
  a_read_soft0: assert property (
    i_rd && i_addr == OFF_SOFT_RESET_0 |=> o_rdata == $past(srst0))
    else $error("soft reset 0 word read back wrong");
  a_cfg_bits: assert property (
    run_cfg[31:28] == 4'h0 && run_cfg[26:0] == 27'h000_0000)
    else $error("config word holds an unused bit");
endmodule // clock_gate_soft_reset
`default_nettype wire

// *** rtl/gate_select.sv ***
`timescale 1ns/1ps
`default_nettype none
// Picks the gating word in force for the current power state
module gate_select (
  input wire clk_rst_pkg::power_state_t i_state, // Power state
  input wire logic i_auto_gating, // Auto-gating enabled
  input wire logic [31:0] i_run, // Run gating word
  input wire logic [31:0] i_sleep, // Sleep gating word
  input wire logic [31:0] i_deep, // Deep-sleep gating word
  output logic [31:0] o_gate // Gating in force
);
  import clk_rst_pkg::*;

  // Without auto gating the run word stays in force during sleep
  always_comb begin
    o_gate = i_run;
    if (i_auto_gating) begin
      case (i_state)
        PWR_SLEEP: o_gate = i_sleep;
        PWR_DEEP_SLEEP: o_gate = i_deep;
        default: o_gate = i_run;
      endcase
    end
  end
endmodule // gate_select
`default_nettype wire

// *** rtl/masked_reg.sv ***
`timescale 1ns/1ps
`default_nettype none
// One software-writable word with a capability mask
module masked_reg #(
  parameter logic [31:0] IMPL_MASK = 32'h0000_0000,
  parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
  input wire logic i_ref_clk, // System clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_we, // Write strobe for this word
  input wire logic [31:0] i_wdata, // Write data
  input wire logic [31:0] i_cap_mask, // Units present
  output logic [31:0] o_value // Stored value
);
  logic [31:0] wmask;

  // Reserved and absent bits never change
  assign wmask = IMPL_MASK & i_cap_mask;

  // Store masked write
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_value <= RST_VAL;
    end else if (i_we) begin
      o_value <= (o_value & ~wmask) | (i_wdata & wmask);
    end
  end
endmodule // masked_reg
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import clk_rst_pkg::*;
  logic i_ref_clk, i_rst_n, i_wr, i_rd;
  logic [11:0] i_addr;
  logic [31:0] i_wdata, i_cap_one, i_cap_two, i_cap_four;
  power_state_t i_power_state;
  unit_access_t i_access;
  logic [31:0] o_rdata, o_clock_enable;
  logic o_access_fault;
  soft_reset_t o_soft_reset;
  int fail_count = 0;
  int tests_run = 0;

  clock_gate_soft_reset clock_gate_soft_reset_inst (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_cap_one(i_cap_one), .i_cap_two(i_cap_two), .i_cap_four(i_cap_four),
    .i_power_state(i_power_state), .i_access(i_access),
    .o_access_fault(o_access_fault), .o_clock_enable(o_clock_enable),
    .o_soft_reset(o_soft_reset));

  // 125 MHz system clock
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single-cycle write, strobe dropped on the following edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask

  // Registered outputs need two edges after a change lands
  task automatic settle;
    repeat (3) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic words(input logic [31:0] w0, w1, w2);
    rd(12'h040, w0);
    rd(12'h044, w1);
    rd(12'h048, w2);
    settle();
    chk(o_soft_reset.word0, w0);
    chk(o_soft_reset.word1, w1);
    chk(o_soft_reset.word2, w2);
  endtask

  // Fault pulse comes the cycle after the access
  task automatic access(input logic [2:0] u, input logic exp);
    @(posedge i_ref_clk);
    i_access <= '{valid: 1'b1, unit: u};
    @(posedge i_ref_clk);
    i_access <= '{valid: 1'b0, unit: 3'h0};
    #1 chk({31'h0, o_access_fault}, {31'h0, exp});
  endtask

  task automatic t_reset;
    words(32'h0, 32'h0, 32'h0);
    rd(12'h128, 32'h0);
    chk(o_clock_enable, 32'h0);
    access(3'd0, 1'b1);
  endtask

  task automatic t_layout;
    wr(12'h040, 32'hFFFF_FFFF);
    wr(12'h044, 32'hFFFF_FFFF);
    wr(12'h048, 32'hFFFF_FFFF);
    words(32'h0011_0008, 32'h010F_5011, 32'h0000_201F);
  endtask

  // Absent units must keep their old value when cleared
  task automatic t_cap_mask;
    @(posedge i_ref_clk);
    i_cap_one <= 32'h0010_0000;
    i_cap_two <= 32'h0000_1001;
    i_cap_four <= 32'h0000_2001;
    wr(12'h040, 32'h0);
    wr(12'h044, 32'h0);
    wr(12'h048, 32'h0);
    words(32'h0001_0008, 32'h010F_4010, 32'h0000_001E);
    @(posedge i_ref_clk);
    i_cap_one <= 32'hFFFF_FFFF;
    i_cap_two <= 32'hFFFF_FFFF;
    i_cap_four <= 32'hFFFF_FFFF;
    wr(12'h040, 32'h0);
    wr(12'h044, 32'h0);
    wr(12'h048, 32'h0);
    words(32'h0, 32'h0, 32'h0);
  endtask

  task automatic t_gating;
    logic [31:0] g;
    wr(12'h108, 32'hFFFF_FFFF);
    wr(12'h118, 32'h0000_0012);
    wr(12'h128, 32'hFFFF_DFFA);
    rd(12'h108, 32'h0000_201F);
    rd(12'h128, 32'h0000_001A);
    wr(12'h128, 32'h0000_2005);
    settle();
    chk(o_clock_enable, 32'h0000_201F);
    @(posedge i_ref_clk);
    i_power_state <= PWR_DEEP_SLEEP;
    settle();
    chk(o_clock_enable, 32'h0000_201F);
    wr(12'h060, 32'h0800_0000);
    settle();
    chk(o_clock_enable, 32'h0000_2005);
    g = 32'h0000_2005;
    for (int u = 0; u < 7; u++) begin
      access(3'(u), u == 6 ? 1'b1 : !g[u < 5 ? u : 13]);
    end
    @(posedge i_ref_clk);
    i_power_state <= PWR_SLEEP;
    settle();
    chk(o_clock_enable, 32'h0000_0012);
    rd(12'h180, 32'h0000_0001);
    access(3'd1, 1'b0);
    access(3'd0, 1'b1);
  endtask

  task automatic t_unmapped;
    wr(12'h04C, 32'hFFFF_FFFF);
    rd(12'h04C, 32'h0);
    rd(12'h128, 32'h0000_2005);
  endtask

  // Whole run is about 120 cycles; cut a hang well beyond that
  initial begin
    #200000;
    fail_count++;
    conclude();
  end

  initial begin
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 12'h0;
    i_wdata = 32'h0;
    i_cap_one = 32'hFFFF_FFFF;
    i_cap_two = 32'hFFFF_FFFF;
    i_cap_four = 32'hFFFF_FFFF;
    i_power_state = PWR_RUN;
    i_access = '{valid: 1'b0, unit: 3'h0};
    repeat (5) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_layout();
    t_cap_mask();
    t_gating();
    t_unmapped();
    conclude();
  end
endmodule // tb
`default_nettype wire
